//--- rtl/tsbo_observer.sv
// How it works
// - register reads wait for context sync
// - register reads wait for barrier completion
// - observe every instruction outside prohibited regions
// - drain earlier execution before context sync
// - observe exceptions outside prohibited regions
// - barrier raises a trace sync event
// - prohibited barrier waits for pause or idle
// - event finishes once prior tracing drained
// - enabled inside prohibited region stays silent
// - after prohibited barrier, silent until exit
`timescale 1ns/1ps
`default_nettype none
module tsbo_observer
  import tsbo_pkg::*;
(
  input wire logic I_CLK,                     // core clock, 40 MHz
  input wire logic I_RSTN,                    // async reset, active low
  input wire tsbo_retire_t I_RETIRE,          // retiring instruction
  input wire logic I_PROHIBITED,              // pipeline in prohibited region
  input wire logic I_TRACE_EN,                // trace unit enabled
  input wire logic I_RES_PAUSED,              // trace resources paused
  input wire logic I_UNIT_IDLE,               // unit idle or stable
  input wire logic I_SYSREG_RD_REQ,           // indirect system register read
  output tsbo_obs_t O_OBS,                    // observed item
  output logic O_SYNC_EVENT,                  // trace sync event pulse
  output logic O_BARRIER_DONE,                // barrier may retire
  output logic O_SYSREG_RD_GRANT,             // read may sample now
  output logic [3:0] O_ROM_CLASS,             // requester table class
  output logic O_PWR_ID_VALID,                // power_domain_id_valid
  output logic [4:0] O_PWR_ID                 // power_domain_identifier
);

  // ***************************************************************
  // state
  // ***************************************************************
  tsbo_state_t state;
  tsbo_state_t next_state;
  logic quiet;
  logic drained;
  logic csync_pending;
  logic barrier_open;
  logic barrier_taken;
  logic barrier_in_region;
  logic observe;

  // ***************************************************************
  // retire decoding
  // ***************************************************************
  function automatic logic takes_barrier(input tsbo_retire_t r);
    return r.valid && r.is_barrier;
  endfunction : takes_barrier

  function automatic logic takes_csync(input tsbo_retire_t r);
    return r.valid && r.is_csync;
  endfunction : takes_csync

  // a barrier is only taken while no other one is in service
  assign barrier_open = (state == TSBO_ST_RUN) || (state == TSBO_ST_QUIET);
  assign barrier_taken = barrier_open && takes_barrier(I_RETIRE);

  // every retired item outside prohibited regions, barriers included;
  // quiet only ever silences inside the region, so the first cycle after
  // leaving it is traced at once
  assign observe = I_RETIRE.valid && !I_PROHIBITED && I_TRACE_EN
                   && !(quiet && I_PROHIBITED);

  tsbo_drain u_drain (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_obs(observe),
    .o_empty(drained)
  );

  // ***************************************************************
  // barrier sequencing
  // ***************************************************************
  always_comb begin
    next_state = state;
    case (state)
      TSBO_ST_RUN, TSBO_ST_QUIET: begin
        if (takes_barrier(I_RETIRE)) begin
          next_state = TSBO_ST_DRAIN;
        end else if (state == TSBO_ST_QUIET && !I_PROHIBITED) begin
          next_state = TSBO_ST_RUN;
        end
      end
      TSBO_ST_DRAIN: begin
        if (drained) begin
          next_state = barrier_in_region ? TSBO_ST_WAIT_PAUSE : TSBO_ST_DONE;
        end
      end
      TSBO_ST_WAIT_PAUSE: begin
        if (I_RES_PAUSED || I_UNIT_IDLE) begin
          next_state = TSBO_ST_DONE;
        end
      end
      TSBO_ST_DONE: begin
        next_state = I_PROHIBITED ? TSBO_ST_QUIET : TSBO_ST_RUN;
      end
      default: begin
        next_state = TSBO_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state <= TSBO_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // the region is taken from where the barrier executed, not from where
  // the pipeline happens to stand once the drain ends
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      barrier_in_region <= 1'b0;
    end else if (barrier_taken) begin
      barrier_in_region <= I_PROHIBITED;
    end
  end

  // ***************************************************************
  // silence while inside a prohibited region
  // ***************************************************************
  // set while trace is disabled inside the region or after a finished barrier there;
  // leaving the region wins over both
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      quiet <= 1'b0;
    end else if (!I_PROHIBITED) begin
      quiet <= 1'b0;
    end else if (!I_TRACE_EN) begin
      quiet <= 1'b1;
    end else if (state == TSBO_ST_DONE) begin
      quiet <= 1'b1;
    end
  end

  // ***************************************************************
  // context sync drain and indirect register reads
  // ***************************************************************
  // the set wins: a new context sync in the drain cycle stays pending
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      csync_pending <= 1'b0;
    end else if (takes_csync(I_RETIRE)) begin
      csync_pending <= 1'b1;
    end else if (drained) begin
      csync_pending <= 1'b0;
    end
  end

  // reads sample only once prior execution has drained and no barrier
  // is in service, trading read latency for ordering; a barrier or a
  // context sync retiring in this very cycle holds the read back too,
  // since the grant would otherwise show one cycle after it retired
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_SYSREG_RD_GRANT <= 1'b0;
    end else begin
      O_SYSREG_RD_GRANT <= I_SYSREG_RD_REQ && !csync_pending && drained
                           && barrier_open && !takes_barrier(I_RETIRE)
                           && !takes_csync(I_RETIRE);
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_OBS <= '0;
    end else begin
      O_OBS.valid <= observe;
      O_OBS.pc <= I_RETIRE.pc;
      O_OBS.is_exception <= I_RETIRE.is_exception;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_SYNC_EVENT <= 1'b0;
    end else begin
      O_SYNC_EVENT <= barrier_taken;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_BARRIER_DONE <= 1'b0;
    end else begin
      // done state lasts one cycle, so the pipeline sees a single pulse
      // and releases the stalled barrier exactly once
      O_BARRIER_DONE <= (next_state == TSBO_ST_DONE);
    end
  end

  // constant description of the power-up requester entry; kept in flops
  // so that every output of the block leaves a register
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_ROM_CLASS <= TSBO_ROM_CLASS;
      O_PWR_ID_VALID <= TSBO_PWR_ID_VALID;
      O_PWR_ID <= TSBO_PWR_ID_DEFAULT;
    end else begin
      O_ROM_CLASS <= TSBO_ROM_CLASS;
      O_PWR_ID_VALID <= TSBO_PWR_ID_VALID;
      O_PWR_ID <= TSBO_PWR_ID_DEFAULT;
    end
  end

endmodule : tsbo_observer
`default_nettype wire

//--- rtl/tsbo_pkg.sv
package tsbo_pkg;

  // ***************************************************************
  // power-up request description (held by the system ROM table)
  // ***************************************************************
  localparam logic [3:0] TSBO_ROM_CLASS = 4'h9;
  localparam logic TSBO_PWR_ID_VALID = 1'h1;
  // identifier value is arbitrary
  localparam logic [4:0] TSBO_PWR_ID_DEFAULT = 5'h00;

  // ***************************************************************
  // widths and reset values
  // ***************************************************************
  localparam int TSBO_PC_W = 32;
  localparam int TSBO_DRAIN_W = 4;
  localparam logic [TSBO_DRAIN_W-1:0] TSBO_DRAIN_CYCLES = 4'h3;
  localparam logic [TSBO_DRAIN_W-1:0] TSBO_DRAIN_RESET = 4'h0;
  localparam logic [7:0] TSBO_CNT_RESET = 8'h00;

  // retired instruction as presented by the pipeline
  typedef struct packed {
    logic valid;
    logic [TSBO_PC_W-1:0] pc;
    logic is_csync;
    logic is_barrier;
    logic is_exception;
  } tsbo_retire_t;

  // one observed item handed to the trace stream
  typedef struct packed {
    logic valid;
    logic [TSBO_PC_W-1:0] pc;
    logic is_exception;
  } tsbo_obs_t;

  typedef enum logic [2:0] {
    TSBO_ST_RUN = 3'b000,
    TSBO_ST_DRAIN = 3'b001,
    TSBO_ST_WAIT_PAUSE = 3'b010,
    TSBO_ST_DONE = 3'b011,
    TSBO_ST_QUIET = 3'b100
  } tsbo_state_t;

endpackage : tsbo_pkg

//--- rtl/tsbo_drain.sv
`timescale 1ns/1ps
`default_nettype none
module tsbo_drain
  import tsbo_pkg::*;
(
  input wire logic i_clk,      // core clock
  input wire logic i_rstn,     // async reset, active low
  input wire logic i_obs,      // an item entered the trace path
  output logic o_empty         // no item still in flight
);

  // ***************************************************************
  // in-flight drain timer
  // ***************************************************************
  // each observed item needs a fixed number of cycles to leave the
  // trace path; a fresh item restarts the wait
  logic [TSBO_DRAIN_W-1:0] cnt;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= TSBO_DRAIN_RESET;
    end else if (i_obs) begin
      cnt <= TSBO_DRAIN_CYCLES;
    end else if (cnt != TSBO_DRAIN_RESET) begin
      cnt <= cnt - 4'h1;
    end
  end

  assign o_empty = (cnt == TSBO_DRAIN_RESET) && !i_obs;

endmodule : tsbo_drain
`default_nettype wire

//--- tb/tsbo_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tsbo_properties
  import tsbo_pkg::*;
(
  input wire logic I_CLK, // clock
  input wire logic I_RSTN, // reset
  input wire tsbo_retire_t I_RETIRE, // retire
  input wire logic I_PROHIBITED, // region
  input wire logic I_TRACE_EN, // enable
  input wire logic I_RES_PAUSED, // paused
  input wire logic I_UNIT_IDLE, // idle
  input wire logic I_SYSREG_RD_REQ, // read
  input wire tsbo_obs_t O_OBS, // observed
  input wire logic O_SYNC_EVENT, // event
  input wire logic O_BARRIER_DONE, // done
  input wire logic O_SYSREG_RD_GRANT, // grant
  input wire logic [3:0] O_ROM_CLASS, // class
  input wire logic O_PWR_ID_VALID, // id valid
  input wire logic [4:0] O_PWR_ID // id
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  // *****
  // barrier steps
  // *****
  sequence s_stuck;
    I_PROHIBITED && !I_RES_PAUSED && !I_UNIT_IDLE;
  endsequence
  sequence s_sync_free;
    O_SYNC_EVENT && !I_PROHIBITED;
  endsequence
  a_obs_cause: assert property (O_OBS.valid |-> $past(I_RETIRE.valid && !I_PROHIBITED && I_TRACE_EN))
    else $error("observation without cause");
  a_obs_content: assert property (O_OBS.valid |-> O_OBS.pc == $past(I_RETIRE.pc)
    && O_OBS.is_exception == $past(I_RETIRE.is_exception))
    else $error("observation content wrong");
  a_no_obs_prohib: assert property (I_PROHIBITED |=> !O_OBS.valid)
    else $error("trace inside region");
  a_sync_cause: assert property (O_SYNC_EVENT |-> $past(I_RETIRE.valid && I_RETIRE.is_barrier))
    else $error("event without barrier");
  a_done_pulse: assert property (O_BARRIER_DONE |=> !O_BARRIER_DONE)
    else $error("done not a pulse");
  a_wait_pause: assert property (s_stuck |=> !O_BARRIER_DONE)
    else $error("done before pause");
  a_drain_bound: assert property (s_sync_free |-> ##[1:6] O_BARRIER_DONE)
    else $error("done late");
  a_grant_block: assert property (O_SYNC_EVENT |=> !O_SYSREG_RD_GRANT)
    else $error("grant during barrier");
  a_rom_const: assert property (O_ROM_CLASS == TSBO_ROM_CLASS && O_PWR_ID_VALID)
    else $error("table entry wrong");
  a_grant_csync: assert property ((I_RETIRE.valid && I_RETIRE.is_csync) |=> !O_SYSREG_RD_GRANT)
    else $error("grant beside context sync");
  a_grant_barrier: assert property ((I_RETIRE.valid && I_RETIRE.is_barrier) |=> !O_SYSREG_RD_GRANT)
    else $error("grant beside barrier");
endmodule : tsbo_properties
bind tsbo_observer tsbo_properties u_props (.I_CLK, .I_RSTN, .I_RETIRE, .I_PROHIBITED, .I_TRACE_EN,
  .I_RES_PAUSED, .I_UNIT_IDLE, .I_SYSREG_RD_REQ, .O_OBS, .O_SYNC_EVENT, .O_BARRIER_DONE,
  .O_SYSREG_RD_GRANT, .O_ROM_CLASS, .O_PWR_ID_VALID, .O_PWR_ID);
`default_nettype wire

//--- tb/tsbo_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsbo_pipe_model
  import tsbo_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_rstn, // reset, active low
  input wire logic i_go, // issue
  input wire tsbo_retire_t i_req, // item
  input wire logic i_done, // complete
  output tsbo_retire_t o_retire, // retire
  output var logic o_busy // stalled
);
  // a stalled barrier blocks all later retirement
  assign o_retire = (i_go && !o_busy) ? i_req : '0;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) o_busy <= 1'b0;
    else if (i_go && i_req.is_barrier && !o_busy) o_busy <= 1'b1;
    else if (i_done) o_busy <= 1'b0;
  end
endmodule : tsbo_pipe_model
`default_nettype wire

//--- tb/trace_sync_barrier_observer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module trace_sync_barrier_observer_bench;
  import tsbo_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, go = 1'b0, prh = 1'b0, en = 1'b1, psd = 1'b0, idl = 1'b0, rrq = 1'b1;
  logic sev, done, gnt, busy, pv;
  logic [3:0] cls;
  logic [4:0] pid;
  tsbo_retire_t req = '0, ret;
  tsbo_obs_t obs;
  int fail_count = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  tsbo_observer dut (.I_CLK(clk), .I_RSTN(rstn), .I_RETIRE(ret), .I_PROHIBITED(prh), .I_TRACE_EN(en),
    .I_RES_PAUSED(psd), .I_UNIT_IDLE(idl), .I_SYSREG_RD_REQ(rrq), .O_OBS(obs), .O_SYNC_EVENT(sev),
    .O_BARRIER_DONE(done), .O_SYSREG_RD_GRANT(gnt), .O_ROM_CLASS(cls), .O_PWR_ID_VALID(pv), .O_PWR_ID(pid));
  tsbo_pipe_model pipe (.i_clk(clk), .i_rstn(rstn), .i_go(go), .i_req(req), .i_done(done), .o_retire(ret),
    .o_busy(busy));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic issue(input logic [31:0] pc, input logic x, input logic b);
    @(negedge clk);
    req = '{1'b1, pc, 1'b0, b, x};
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
  endtask : issue
  task automatic t_rom;
    repeat (6) @(negedge clk);
    chk("rom_class", 32'h9, {28'h0, cls});
    chk("id_valid", 32'h1, {31'h0, pv});
    chk("grant_idle", 32'h1, {31'h0, gnt});
    chk("pwr_id", {27'h0, TSBO_PWR_ID_DEFAULT}, {27'h0, pid});
  endtask : t_rom
  task automatic t_csync;
    rrq = 1'b0;
    @(negedge clk);
    chk("grant_noreq", 32'h0, {31'h0, gnt});
    rrq = 1'b1;
    @(negedge clk);
    req = '{1'b1, 32'h500, 1'b1, 1'b0, 1'b0};
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    chk("grant_csync", 32'h0, {31'h0, gnt});
    repeat (4) @(negedge clk);
    chk("grant_drain", 32'h0, {31'h0, gnt});
    @(negedge clk);
    chk("grant_after", 32'h1, {31'h0, gnt});
  endtask : t_csync
  task automatic t_observe;
    issue(32'h100, 1'b0, 1'b0);
    chk("obs_valid", 32'h1, {31'h0, obs.valid});
    chk("obs_pc", 32'h100, obs.pc);
    issue(32'h104, 1'b1, 1'b0);
    chk("obs_exc", 32'h1, {31'h0, obs.is_exception});
  endtask : t_observe
  task automatic t_barrier(input logic p, input logic [1:0] sel);
    int i;
    prh = p;
    issue(32'h200, 1'b0, 1'b1);
    chk("sync_event", 32'h1, {31'h0, sev});
    chk("obs_barrier", {31'h0, !p}, {31'h0, obs.valid});
    chk("grant_barrier", 32'h0, {31'h0, gnt});
    if (p) begin
      repeat (10) @(negedge clk);
      chk("done_held", 32'h0, {31'h0, done});
      chk("grant_held", 32'h0, {31'h0, gnt});
      {psd, idl} = sel;
    end
    for (i = 0; i < 12 && done !== 1'b1; i++) @(negedge clk);
    chk("barrier_done", 32'h1, {31'h0, done});
    {psd, idl} = 2'b00;
    issue(32'h300, 1'b0, 1'b0);
    chk("obs_after", {31'h0, !p}, {31'h0, obs.valid});
    prh = 1'b0;
    issue(32'h304, 1'b0, 1'b0);
    chk("obs_exit", 32'h1, {31'h0, obs.valid});
  endtask : t_barrier
  task automatic t_quiet;
    en = 1'b0;
    prh = 1'b1;
    @(negedge clk);
    en = 1'b1;
    issue(32'h400, 1'b1, 1'b0);
    chk("obs_enabled_in", 32'h0, {31'h0, obs.valid});
    // leave the region in the very cycle the next item retires
    @(negedge clk);
    prh = 1'b0;
    req = '{1'b1, 32'h404, 1'b0, 1'b0, 1'b0};
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    chk("obs_enabled_out", 32'h1, {31'h0, obs.valid});
  endtask : t_quiet
  task automatic t_reset;
    prh = 1'b1;
    issue(32'h600, 1'b0, 1'b1);
    repeat (6) @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    chk("rst_done", 32'h0, {31'h0, done});
    chk("rst_grant", 32'h0, {31'h0, gnt});
    chk("rst_class", {28'h0, TSBO_ROM_CLASS}, {28'h0, cls});
    chk("rst_id_valid", 32'h1, {31'h0, pv});
    rstn = 1'b1;
    prh = 1'b0;
    issue(32'h604, 1'b0, 1'b0);
    chk("obs_rst", 32'h1, {31'h0, obs.valid});
  endtask : t_reset
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // *****
  // sequence and watchdog
  // *****
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    t_rom();
    t_csync();
    t_observe();
    t_barrier(1'b0, 2'b00);
    t_barrier(1'b1, 2'b10);
    t_barrier(1'b1, 2'b01);
    t_quiet();
    t_reset();
    conclude();
  end
  // about 100 cycles are needed; allow twenty times that
  initial begin
    #50000;
    fail_count++;
    conclude();
  end
endmodule : trace_sync_barrier_observer_bench
`default_nettype wire
